// ==== verilog/quhb_bus_port.sv ====
// Host parallel bus port of a four-channel UART, both bus styles
`default_nettype none

module quhb_bus_port #(
    parameter int RD_LATENCY = quhb_pkg::RD_LATENCY
) (
    input wire logic core_clk,
    input wire logic rst_b,
    // Host pins
    input wire logic bus_mode,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic channel_a_select_n,
    input wire logic channel_b_select_n,
    input wire logic channel_c_select_n,
    input wire logic channel_d_select_n,
    input wire logic [quhb_pkg::ADDR_W-1:0] bus_addr,
    input wire logic [quhb_pkg::DATA_W-1:0] bus_data_in,
    output logic [quhb_pkg::DATA_W-1:0] bus_data_out,
    output logic bus_data_oe,
    // Register side, same clock
    output logic [quhb_pkg::CHAN_W-1:0] reg_chan,
    output logic [quhb_pkg::ADDR_W-1:0] reg_addr,
    output logic [quhb_pkg::DATA_W-1:0] reg_wdata,
    output logic reg_write,
    output logic reg_read,
    input wire logic [quhb_pkg::DATA_W-1:0] reg_rdata,
    output logic busy
);

    logic [quhb_pkg::CTRL_W-1:0] ctrl_level;
    logic [quhb_pkg::CTRL_W-1:0] ctrl_prev;
    logic [quhb_pkg::BUS_W-1:0] bus_level;
    quhb_pkg::quhb_state_e state;
    quhb_pkg::quhb_state_e next_state;
    logic txn_mode;
    logic [quhb_pkg::CHAN_W-1:0] txn_chan;
    logic [quhb_pkg::LAT_W-1:0] lat_count;

    logic mode;
    logic rd_n;
    logic wr_n;
    logic sel_a_n;
    logic sel_b_n;
    logic sel_c_n;
    logic sel_d_n;
    logic [quhb_pkg::ADDR_W-1:0] addr_now;
    logic [quhb_pkg::DATA_W-1:0] data_now;

    logic sel_any;
    logic [quhb_pkg::CHAN_W-1:0] sel_chan;
    logic start_rd;
    logic start_wr;
    logic [quhb_pkg::CHAN_W-1:0] start_chan;
    logic end_rd;
    logic end_wr;
    logic still_enabled;
    logic fetch_done;

    // Control pins and address/data pins cross into core_clk separately
    quhb_pin_sync #(
        .WIDTH(quhb_pkg::CTRL_W),
        .RESET_VAL(quhb_pkg::CTRL_RESET)
    ) u_ctrl_sync (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .pin({bus_mode, read_strobe_n, write_strobe_n, channel_a_select_n,
              channel_b_select_n, channel_c_select_n, channel_d_select_n}),
        .level(ctrl_level)
    );

    quhb_pin_sync #(
        .WIDTH(quhb_pkg::BUS_W),
        .RESET_VAL(quhb_pkg::BUS_RESET)
    ) u_bus_sync (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .pin({bus_addr, bus_data_in}),
        .level(bus_level)
    );

    assign mode = ctrl_level[quhb_pkg::CTRL_MODE];
    assign rd_n = ctrl_level[quhb_pkg::CTRL_RD];
    assign wr_n = ctrl_level[quhb_pkg::CTRL_WR];
    assign sel_a_n = ctrl_level[quhb_pkg::CTRL_CSA];
    assign sel_b_n = ctrl_level[quhb_pkg::CTRL_CSB];
    assign sel_c_n = ctrl_level[quhb_pkg::CTRL_CSC];
    assign sel_d_n = ctrl_level[quhb_pkg::CTRL_CSD];
    assign addr_now = bus_level[quhb_pkg::BUS_W-1:quhb_pkg::DATA_W];
    assign data_now = bus_level[quhb_pkg::DATA_W-1:0];

    // Strobe mode channel from the four selects; a host that breaks the one-select
    // convention gets the lowest channel rather than a merged access
    function automatic logic [quhb_pkg::CHAN_W-1:0] select_chan(
        input logic a_n,
        input logic b_n,
        input logic c_n
    );
        logic [quhb_pkg::CHAN_W-1:0] chan;
        chan = quhb_pkg::CHAN_D;
        if (!a_n) begin
            chan = quhb_pkg::CHAN_A;
        end else if (!b_n) begin
            chan = quhb_pkg::CHAN_B;
        end else if (!c_n) begin
            chan = quhb_pkg::CHAN_C;
        end
        return chan;
    endfunction

    // True while the select of the given channel is still asserted
    function automatic logic chan_selected(
        input logic [quhb_pkg::CHAN_W-1:0] chan,
        input logic [quhb_pkg::CTRL_W-1:0] ctrl
    );
        logic sel;
        sel = 1'b0;
        case (chan)
            quhb_pkg::CHAN_A: sel = !ctrl[quhb_pkg::CTRL_CSA];
            quhb_pkg::CHAN_B: sel = !ctrl[quhb_pkg::CTRL_CSB];
            quhb_pkg::CHAN_C: sel = !ctrl[quhb_pkg::CTRL_CSC];
            default: sel = !ctrl[quhb_pkg::CTRL_CSD];
        endcase
        return sel;
    endfunction

    assign sel_any = !(sel_a_n && sel_b_n && sel_c_n && sel_d_n); // R8 R10 R11 R13
    assign sel_chan = select_chan(sel_a_n, sel_b_n, sel_c_n); // R15

    always_comb begin
        start_rd = 1'b0;
        start_wr = 1'b0;
        start_chan = sel_chan;
        end_rd = 1'b0;
        end_wr = 1'b0;
        still_enabled = 1'b1;
        if (mode == quhb_pkg::MODE_STROBE) begin // R1
            // Falling strobe edge with a channel selected opens a cycle
            start_rd = ctrl_prev[quhb_pkg::CTRL_RD] && !rd_n && sel_any; // R3
            start_wr = ctrl_prev[quhb_pkg::CTRL_WR] && !wr_n && sel_any && rd_n; // R5
            end_rd = !ctrl_prev[quhb_pkg::CTRL_RD] && rd_n; // R4
            end_wr = !ctrl_prev[quhb_pkg::CTRL_WR] && wr_n; // R5
            still_enabled = chan_selected(txn_chan, ctrl_level); // R8 R10 R11 R13
        end else begin
            // Read strobe and channel D select play no part here
            start_rd = ctrl_prev[quhb_pkg::CTRL_CSA] && !sel_a_n
                       && (wr_n == quhb_pkg::DIR_READ); // R6 R7 R9
            start_wr = ctrl_prev[quhb_pkg::CTRL_CSA] && !sel_a_n
                       && (wr_n == quhb_pkg::DIR_WRITE); // R7 R9
            start_chan = {sel_c_n, sel_b_n}; // R12 R14
            end_rd = !ctrl_prev[quhb_pkg::CTRL_CSA] && sel_a_n; // R9
            end_wr = end_rd; // R9
        end
    end

    assign fetch_done = (lat_count == quhb_pkg::LAT_W'(RD_LATENCY));

    always_comb begin
        next_state = state;
        case (state)
            quhb_pkg::QUHB_IDLE: begin
                if (start_rd) begin
                    next_state = quhb_pkg::QUHB_RD_FETCH;
                end else if (start_wr) begin
                    next_state = quhb_pkg::QUHB_WR_WAIT;
                end
            end
            quhb_pkg::QUHB_RD_FETCH: begin
                if (mode != txn_mode || !still_enabled || end_rd) begin
                    next_state = quhb_pkg::QUHB_IDLE;
                end else if (fetch_done) begin
                    next_state = quhb_pkg::QUHB_RD_DRIVE;
                end
            end
            quhb_pkg::QUHB_RD_DRIVE: begin
                if (mode != txn_mode || !still_enabled || end_rd) begin // R4
                    next_state = quhb_pkg::QUHB_IDLE;
                end
            end
            quhb_pkg::QUHB_WR_WAIT: begin
                if (mode != txn_mode || !still_enabled || end_wr) begin
                    next_state = quhb_pkg::QUHB_IDLE;
                end
            end
            default: next_state = quhb_pkg::QUHB_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            state <= quhb_pkg::QUHB_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            ctrl_prev <= quhb_pkg::CTRL_RESET;
        end else begin
            ctrl_prev <= ctrl_level;
        end
    end

    // Channel and register are frozen at the opening edge for the whole cycle
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            txn_mode <= quhb_pkg::MODE_STROBE;
            txn_chan <= quhb_pkg::CHAN_A;
            reg_chan <= quhb_pkg::CHAN_A;
            reg_addr <= quhb_pkg::ADDR_RESET;
        end else if (state == quhb_pkg::QUHB_IDLE && (start_rd || start_wr)) begin
            txn_mode <= mode;
            txn_chan <= start_chan;
            reg_chan <= start_chan; // R12 R14
            reg_addr <= addr_now; // R2
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            reg_read <= 1'b0;
        end else begin
            reg_read <= (state == quhb_pkg::QUHB_IDLE) && start_rd; // R3
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            lat_count <= '0;
        end else if (state == quhb_pkg::QUHB_RD_FETCH) begin
            lat_count <= lat_count + quhb_pkg::LAT_W'(1);
        end else begin
            lat_count <= '0;
        end
    end

    // Write lands only on the closing edge, and only if the select held to the end
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            reg_write <= 1'b0;
            reg_wdata <= quhb_pkg::DOUT_RESET;
        end else if (state == quhb_pkg::QUHB_WR_WAIT && end_wr
                     && mode == txn_mode && still_enabled) begin
            reg_write <= 1'b1; // R5
            reg_wdata <= data_now; // R5
        end else begin
            reg_write <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            bus_data_out <= quhb_pkg::DOUT_RESET;
        end else if (state == quhb_pkg::QUHB_RD_FETCH && fetch_done) begin
            bus_data_out <= reg_rdata; // R3
        end
    end

    // Drive only while the read is open; releasing at the close lets the host latch
    // on its own rising strobe with the byte still held by the pin pads
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            bus_data_oe <= 1'b0;
        end else begin
            bus_data_oe <= (next_state == quhb_pkg::QUHB_RD_DRIVE); // R3 R4
        end
    end

    assign busy = (state != quhb_pkg::QUHB_IDLE);

endmodule

`default_nettype wire

// ==== pkg/quhb_pkg.sv ====
// Constants, types and states shared by the quad UART host bus port
// Functional notes
// R1 - Mode pin high selects strobe bus; low selects read/write-line bus with one select.
// R2 - Three address inputs pick the register inside the selected channel.
// R3 - Strobe mode: read strobe falling edge fetches addressed byte and drives data bus.
// R4 - Strobe mode: host captures read byte at the read strobe rising edge.
// R5 - Strobe mode: write strobe falls to start; byte stored at its rising edge.
// R6 - Read/write-line mode: read strobe input is ignored entirely.
// R7 - Read/write-line mode: write strobe pin is direction, high read, low write.
// R8 - Strobe mode: channel A enabled only while its select is low.
// R9 - Read/write-line mode: channel A select is the single device chip select.
// R10 - Strobe mode: channel B enabled only while its select is low.
// R11 - Strobe mode: channel C enabled only while its select is low.
// R12 - Read/write-line mode: B and C selects become channel address bits A3, A4.
// R13 - Strobe mode: channel D enabled only while its select is low; else unused.
// R14 - Read/write-line mode: A4:A3 values 0 to 3 map to channels A to D.
// R15 - Host asserts one select at a time and holds address through each strobe.
`default_nettype none

package quhb_pkg;

    localparam int DATA_W = 8;
    localparam int ADDR_W = 3;
    localparam int CHAN_W = 2;
    localparam int SYNC_STAGES = 3;
    localparam int CTRL_W = 7;
    localparam int BUS_W = ADDR_W + DATA_W;

    // Bus mode pin and direction line levels
    localparam logic MODE_STROBE = 1'b1;
    localparam logic MODE_RWLINE = 1'b0;
    localparam logic DIR_READ = 1'b1;
    localparam logic DIR_WRITE = 1'b0;

    // Channel codes on the register side
    localparam logic [CHAN_W-1:0] CHAN_A = 2'h0;
    localparam logic [CHAN_W-1:0] CHAN_B = 2'h1;
    localparam logic [CHAN_W-1:0] CHAN_C = 2'h2;
    localparam logic [CHAN_W-1:0] CHAN_D = 2'h3;

    // Bit positions inside the synchronised control word
    localparam int CTRL_MODE = 6;
    localparam int CTRL_RD = 5;
    localparam int CTRL_WR = 4;
    localparam int CTRL_CSA = 3;
    localparam int CTRL_CSB = 2;
    localparam int CTRL_CSC = 1;
    localparam int CTRL_CSD = 0;

    // Reset values: strobes and selects idle high, strobe mode assumed
    localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h7f;
    localparam logic [BUS_W-1:0] BUS_RESET = 11'h000;
    localparam logic [DATA_W-1:0] DOUT_RESET = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 3'h0;

    // Cycles from the register read pulse to read data being valid
    localparam int RD_LATENCY = 1;
    localparam int LAT_W = 4;

    typedef enum {
        QUHB_IDLE,
        QUHB_RD_FETCH,
        QUHB_RD_DRIVE,
        QUHB_WR_WAIT
    } quhb_state_e;

endpackage

`default_nettype wire

// ==== verilog/quhb_pin_sync.sv ====
// Three-stage pin synchroniser with agreement filter
`default_nettype none

module quhb_pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] level
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            stage1 <= RESET_VAL;
            stage2 <= RESET_VAL;
            stage3 <= RESET_VAL;
        end else begin
            stage1 <= pin;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // Each bit follows only once the last two stages agree, so a single-cycle
    // metastable settle cannot reach the edge detectors downstream
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            level <= RESET_VAL;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (stage2[i] == stage3[i]) begin
                    level[i] <= stage3[i];
                end
            end
        end
    end

endmodule

`default_nettype wire

// ==== verification/quhb_bus_port_assertions.sv ====
// Checker for the quad UART host bus port
`default_nettype none

module quhb_chk #(
    parameter int RD_LATENCY = quhb_pkg::RD_LATENCY
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic bus_mode,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic channel_a_select_n,
    input wire logic channel_b_select_n,
    input wire logic channel_c_select_n,
    input wire logic channel_d_select_n,
    input wire logic [quhb_pkg::ADDR_W-1:0] bus_addr,
    input wire logic [quhb_pkg::DATA_W-1:0] bus_data_in,
    input wire logic [quhb_pkg::DATA_W-1:0] bus_data_out,
    input wire logic bus_data_oe,
    input wire logic [quhb_pkg::CHAN_W-1:0] reg_chan,
    input wire logic [quhb_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [quhb_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [quhb_pkg::DATA_W-1:0] reg_rdata,
    input wire logic busy
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // Pins reach the block about 4 edges late, so causes are looked up 3 and 8 edges back
    property p_rd_pulse; reg_read |=> !reg_read; endproperty
    a_rd_pulse: assert property (p_rd_pulse) else $error("read pulse too long");
    property p_wr_pulse; reg_write |=> !reg_write; endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("write pulse too long");
    property p_oe_rise; $rose(bus_data_oe) |-> $past(reg_read) || $past(reg_read, 2); endproperty
    a_oe_rise: assert property (p_oe_rise) else $error("drive without fetch");
    property p_oe_data; bus_data_oe |-> bus_data_out == reg_rdata; endproperty
    a_oe_data: assert property (p_oe_data) else $error("wrong byte driven");
    property p_rd_strb;
        reg_read && $past(bus_mode, 8) |-> !$past(read_strobe_n, 3) && $past(read_strobe_n, 8);
    endproperty
    a_rd_strb: assert property (p_rd_strb) else $error("read without strobe fall");
    property p_rd_line;
        reg_read && !$past(bus_mode, 8) |-> $past(write_strobe_n, 3) &&
            !$past(channel_a_select_n, 3) && $past(channel_a_select_n, 8);
    endproperty
    a_rd_line: assert property (p_rd_line) else $error("read without select");
    property p_wr_strb;
        reg_write && $past(bus_mode, 8) |-> $past(write_strobe_n, 3) && !$past(write_strobe_n, 8);
    endproperty
    a_wr_strb: assert property (p_wr_strb) else $error("write not at strobe rise");
    property p_wr_line;
        reg_write && !$past(bus_mode, 8) |-> $past(channel_a_select_n, 3) &&
            !$past(channel_a_select_n, 8) && !$past(write_strobe_n, 8);
    endproperty
    a_wr_line: assert property (p_wr_line) else $error("write not at select rise");
    property p_ch_line;
        reg_write && !$past(bus_mode, 8) |->
            reg_chan == {$past(channel_c_select_n, 8), $past(channel_b_select_n, 8)};
    endproperty
    a_ch_line: assert property (p_ch_line) else $error("wrong channel from A4 A3");
    property p_ch_strb;
        reg_write && $past(bus_mode, 8) |-> reg_chan == (!$past(channel_a_select_n, 8) ? 2'h0 :
            !$past(channel_b_select_n, 8) ? 2'h1 : !$past(channel_c_select_n, 8) ? 2'h2 : 2'h3);
    endproperty
    a_ch_strb: assert property (p_ch_strb) else $error("wrong channel select");
    property p_addr;
        reg_write |-> reg_addr == $past(bus_addr, 8) && reg_wdata == $past(bus_data_in, 8);
    endproperty
    a_addr: assert property (p_addr) else $error("wrong register or byte");
    property p_rd_addr; reg_read |-> reg_addr == $past(bus_addr, 3); endproperty
    a_rd_addr: assert property (p_rd_addr) else $error("read of wrong register");
    property p_busy; (reg_read || bus_data_oe) |-> busy; endproperty
    a_busy: assert property (p_busy) else $error("transfer open but not busy");
    c_rd1: cover property (reg_read && $past(bus_mode, 8));
    c_wr0: cover property (reg_write && !$past(bus_mode, 8));
    c_oe: cover property ($rose(bus_data_oe));
endmodule

bind quhb_bus_port quhb_chk #(.RD_LATENCY(RD_LATENCY)) u_chk (
    .core_clk(core_clk), .rst_b(rst_b), .bus_mode(bus_mode), .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n), .channel_a_select_n(channel_a_select_n),
    .channel_b_select_n(channel_b_select_n), .channel_c_select_n(channel_c_select_n),
    .channel_d_select_n(channel_d_select_n), .bus_addr(bus_addr), .bus_data_in(bus_data_in),
    .bus_data_out(bus_data_out), .bus_data_oe(bus_data_oe), .reg_chan(reg_chan),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .busy(busy));

`default_nettype wire

// ==== verification/quhb_host_model.sv ====
// Host processor model driving the parallel bus pins
`default_nettype none

module quhb_host_model (
    input wire logic core_clk,
    output logic bus_mode,
    output logic read_strobe_n,
    output logic write_strobe_n,
    output logic [3:0] sel_n,
    output logic [quhb_pkg::ADDR_W-1:0] bus_addr,
    output logic [quhb_pkg::DATA_W-1:0] bus_data_in,
    input wire logic [quhb_pkg::DATA_W-1:0] bus_data_out,
    input wire logic bus_data_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic drv;
    logic [7:0] dq;
    // Undriven data lines show the inverse so a stale byte never passes
    always_comb bus_data_in = bus_data_oe ? bus_data_out : (drv ? dq : ~dq);
    initial begin
        bus_mode = 1'b1;
        read_strobe_n = 1'b1;
        write_strobe_n = 1'b1;
        sel_n = 4'hf;
        bus_addr = 3'h0;
        drv = 1'b0;
        dq = 8'h00;
    end
    // kind 0 normal, 1 select dropped before the strobe rises (an early close in mode 0),
    // 2 no select at all
    task automatic xfer(input logic wr, input logic [1:0] ch, input logic [2:0] a,
            input logic [7:0] d, input int kind, output logic [7:0] q);
        @(posedge core_clk) #2;
        bus_addr = a;
        dq = d;
        drv = wr;
        if (bus_mode) begin
            if (kind != 2) sel_n[ch] = 1'b0;
        end else begin
            write_strobe_n = !wr;
            sel_n[2:1] = ch;
            read_strobe_n = 1'($urandom);
            sel_n[3] = 1'($urandom);
        end
        @(posedge core_clk) #2;
        if (!bus_mode) sel_n[0] = 1'(kind == 2);
        else if (wr) write_strobe_n = 1'b0;
        else read_strobe_n = 1'b0;
        repeat (8) @(posedge core_clk);
        if (kind == 1) #2 sel_n = 4'hf;
        repeat (2) @(posedge core_clk);
        q = bus_data_in;
        #2;
        if (bus_mode) {read_strobe_n, write_strobe_n} = 2'h3;
        else sel_n[0] = 1'b1;
        @(posedge core_clk) #2;
        sel_n = 4'hf;
        {read_strobe_n, write_strobe_n} = 2'h3;
        drv = 1'b0;
        bus_addr = ~a;
        repeat (6) @(posedge core_clk);
    endtask
endmodule

`default_nettype wire

// ==== verification/tb.sv ====
// Self-checking bench for the quad UART host bus port
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, rst_b, bus_mode, rd_n, wr_n, bus_data_oe, reg_write, reg_read, busy;
    logic [3:0] sel_n;
    logic [2:0] bus_addr, reg_addr;
    logic [7:0] din, dout, reg_wdata, reg_rdata, q, d;
    logic [1:0] reg_chan;
    logic [7:0] mem [32];
    logic [12:0] exp_q [$];
    logic [12:0] e, ew;
    int error_cnt = 0;
    int checks = 0;

    quhb_host_model uh (.core_clk(core_clk), .bus_mode(bus_mode), .read_strobe_n(rd_n),
        .write_strobe_n(wr_n), .sel_n(sel_n), .bus_addr(bus_addr), .bus_data_in(din),
        .bus_data_out(dout), .bus_data_oe(bus_data_oe));
    quhb_bus_port uut (.core_clk(core_clk), .rst_b(rst_b), .bus_mode(bus_mode),
        .read_strobe_n(rd_n), .write_strobe_n(wr_n), .channel_a_select_n(sel_n[0]),
        .channel_b_select_n(sel_n[1]), .channel_c_select_n(sel_n[2]),
        .channel_d_select_n(sel_n[3]), .bus_addr(bus_addr), .bus_data_in(din),
        .bus_data_out(dout), .bus_data_oe(bus_data_oe), .reg_chan(reg_chan),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .busy(busy));

    // Register side stand-in: one byte per channel and address
    assign reg_rdata = mem[{reg_chan, reg_addr}];
    always @(posedge core_clk) if (reg_write === 1'b1) mem[{reg_chan, reg_addr}] <= reg_wdata;

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    always @(posedge core_clk) begin
        if (rst_b === 1'b1 && reg_write === 1'b1) begin
            ew = (exp_q.size() > 0) ? exp_q.pop_front() : 13'h1fff;
            check("reg_write", {reg_chan, reg_addr, reg_wdata}, ew);
        end
    end

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    initial begin
        #(25ns * 4000);
        error_cnt++;
        end_of_test();
    end

    initial begin
        rst_b = 1'b0;
        foreach (mem[i]) mem[i] = 8'h00;
        void'($urandom(32'h107de40e));
        repeat (4) @(posedge core_clk);
        #2 rst_b = 1'b1;
        for (int m = 1; m >= 0; m--) begin
            @(posedge core_clk) #2 uh.bus_mode = 1'(m);
            repeat (8) @(posedge core_clk);
            for (int ch = 0; ch < 4; ch++) begin
                e[10:0] = 11'($urandom);
                exp_q.push_back({2'(ch), e[10:0]});
                uh.xfer(1'b1, 2'(ch), e[10:8], e[7:0], 0, q);
                uh.xfer(1'b0, 2'(ch), e[10:8], 8'h00, 0, q);
                check("read_byte", q, e[7:0]);
            end
            // Losing the select closes a mode 0 write early but drops a mode 1 write;
            // a write never selected must not land in either mode
            d = mem[{2'h2, 3'h5}] ^ (8'($urandom) | 8'h01);
            if (m == 0) exp_q.push_back({2'h2, 3'h5, d});
            uh.xfer(1'b1, 2'h2, 3'h5, d, 1, q);
            uh.xfer(1'b1, 2'h1, 3'h6, d, 2, q);
            check("read_after_drop", 16'(mem[{2'h2, 3'h5}] === d), 16'(m == 0));
            $display("test mode %0d done", m);
        end
        check("left_over", 16'(exp_q.size()), 16'h0);
        end_of_test();
    end
endmodule

`default_nettype wire
